// File: hdl/tir_consts.vh
// Constants for the multiplexed temperature input word block
`ifndef TIR_CONSTS_VH
`define TIR_CONSTS_VH

// Register byte offsets
`define TIR_ADDR_INPUT 8'h00
`define TIR_ADDR_CTRL 8'h04
`define TIR_ADDR_STAT 8'h08

// Control register fields and reset value
`define TIR_CTRL_EN_LSB 0
`define TIR_CTRL_EN_MSB 3
`define TIR_CTRL_BIPOLAR 4
`define TIR_CTRL_TWOS 5
`define TIR_CTRL_RESET 32'h0000000f

// Input word fields
`define TIR_W_DATA_MSB 15
`define TIR_W_CH_LSB 16
`define TIR_W_CH_MSB 17
`define TIR_W_OPEN_LSB 24
`define TIR_W_OPEN_MSB 27

// Channel geometry
`define TIR_NUM_CH 4
`define TIR_DATA_W 16

// Conversion timing: 160 ms per enabled channel at the 40 MHz bus clock
`define TIR_CONV_CYCLES 32'd6400000

`endif

// File: hdl/tir_converter.v
// Free-running conversion sequencer: one enabled channel per period
`timescale 1ns/1ps
`include "tir_consts.vh"

module tir_converter #(
  parameter [31:0] CONV_CYCLES = `TIR_CONV_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire [3:0] chan_en,
  input wire [15:0] adc_value,
  input wire adc_negative,
  input wire [3:0] sensor_open,
  output reg [1:0] adc_sel,
  output reg store,
  output reg [1:0] store_ch,
  output reg [15:0] store_mag,
  output reg store_neg,
  output reg [3:0] open_now
);

  // Next enabled channel after cur, wrapping; cur itself if alone
  function [1:0] next_ch;
    input [1:0] cur;
    input [3:0] en;
    integer k;
    reg [1:0] c;
    reg found;
    begin
      next_ch = cur;
      found = 1'b0;
      for (k = 1; k <= 4; k = k + 1) begin
        c = cur + k[1:0];
        if (!found && en[c]) begin
          next_ch = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  reg [20:0] sync1;
  reg [20:0] sync2;
  reg [31:0] count;

  // Two-stage synchronisers on the front-end pins; the value is held
  // stable by the front end for the whole period, so bitwise sync is safe
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 21'h000000;
      sync2 <= 21'h000000;
    end else begin
      sync1 <= {sensor_open, adc_negative, adc_value};
      sync2 <= sync1;
    end
  end

  // Conversion runs regardless of the scan; each period ends in a store
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 32'h00000000;
      adc_sel <= 2'h0;
      store <= 1'b0;
      store_ch <= 2'h0;
      store_mag <= 16'h0000;
      store_neg <= 1'b0;
      open_now <= 4'h0;
    end else begin
      store <= 1'b0;
      open_now <= sync2[20:17];
      if (chan_en == 4'h0) begin
        count <= 32'h00000000;
      end else if (!chan_en[adc_sel]) begin
        // Channel was just disabled: move on without storing
        count <= 32'h00000000;
        adc_sel <= next_ch(adc_sel, chan_en);
      end else if (count == CONV_CYCLES - 32'd1) begin
        count <= 32'h00000000;
        store <= 1'b1;
        store_ch <= adc_sel;
        store_mag <= sync2[15:0];
        store_neg <= sync2[16];
        adc_sel <= next_ch(adc_sel, chan_en);
      end else begin
        count <= count + 32'd1;
      end
    end
  end

endmodule // tir_converter

// File: hdl/tir_input_word.v
// Temperature input word: AHB-Lite slave presenting a multiplexed reading
//
// Function
// - The module shows the controller one 32-point input word holding channel, reading and diagnostics.
// - The low 16 bits carry the reading in straight binary, bit n weighing two to the n.
// - A two-bit field names the channel of the reading, 00 for channel 1 up to 11 for channel 4.
// - In magnitude-plus-sign bipolar mode the top data bit is the sign, set for negative.
// - One open-sensor bit per channel sits at word bits 8 to 11 of the upper half.
// - Each scan presents one channel, skipping unused ones and wrapping after the last.
// - Conversion runs apart from the scan at 160 ms per enabled channel.
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "tir_consts.vh"

module tir_input_word #(
  parameter [31:0] CONV_CYCLES = `TIR_CONV_CYCLES
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [15:0] adc_value,
  input wire adc_negative,
  input wire [3:0] sensor_open,
  output reg [1:0] adc_sel
);

  // Same search as in the sequencer: next enabled channel, wrapping
  function [1:0] next_ch;
    input [1:0] cur;
    input [3:0] en;
    integer k;
    reg [1:0] c;
    reg found;
    begin
      next_ch = cur;
      found = 1'b0;
      for (k = 1; k <= 4; k = k + 1) begin
        c = cur + k[1:0];
        if (!found && en[c]) begin
          next_ch = c;
          found = 1'b1;
        end
      end
    end
  endfunction

  reg [31:0] ctrl;
  reg [31:0] word;
  reg [15:0] reading [0:`TIR_NUM_CH-1];
  reg [3:0] fresh;
  reg wr_pend;
  reg [7:0] wr_addr;
  reg [15:0] next_data;
  reg [1:0] next_chan;
  reg [31:0] next_rdata;
  wire [31:0] stat_word;
  wire conv_store;
  wire [1:0] conv_ch;
  wire [15:0] conv_mag;
  wire conv_neg;
  wire [3:0] conv_open;
  wire [1:0] conv_sel;
  wire take;
  wire rd_word;

  assign take = hsel & htrans[1] & hready;
  assign rd_word = take & ~hwrite & (haddr == `TIR_ADDR_INPUT);

  tir_converter #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .hclk(hclk),
    .hresetn(hresetn),
    .chan_en(ctrl[`TIR_CTRL_EN_MSB:`TIR_CTRL_EN_LSB]),
    .adc_value(adc_value),
    .adc_negative(adc_negative),
    .sensor_open(sensor_open),
    .adc_sel(conv_sel),
    .store(conv_store),
    .store_ch(conv_ch),
    .store_mag(conv_mag),
    .store_neg(conv_neg),
    .open_now(conv_open)
  );

  // Next presented channel and its data, already formatted when it was stored
  always @* begin
    next_chan = next_ch(word[`TIR_W_CH_MSB:`TIR_W_CH_LSB],
                        ctrl[`TIR_CTRL_EN_MSB:`TIR_CTRL_EN_LSB]);
    next_data = reading[next_chan];
  end

  // Readings are stored as {sign, 15-bit magnitude}, two's complement or 16-bit unipolar,
  // already in the selected format so a read never mixes two formats
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reading[0] <= 16'h0000;
      reading[1] <= 16'h0000;
      reading[2] <= 16'h0000;
      reading[3] <= 16'h0000;
    end else if (conv_store) begin
      if (!ctrl[`TIR_CTRL_BIPOLAR]) begin
        reading[conv_ch] <= conv_mag;
      end else if (ctrl[`TIR_CTRL_TWOS] && conv_neg) begin
        reading[conv_ch] <= 16'h0000 - {1'b0, conv_mag[14:0]};
      end else begin
        reading[conv_ch] <= {conv_neg, conv_mag[14:0]};
      end
    end
  end

  // Fresh flags: a store in the same cycle as the scan wins over the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fresh <= 4'h0;
    end else begin
      if (rd_word) begin
        fresh[next_chan] <= 1'b0;
      end
      if (conv_store) begin
        fresh[conv_ch] <= 1'b1;
      end
    end
  end

  // Presented word changes only on a scan, as one whole load
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word <= 32'h00000000;
    end else if (rd_word) begin
      word <= 32'h00000000;
      word[`TIR_W_DATA_MSB:0] <= next_data;
      word[`TIR_W_CH_MSB:`TIR_W_CH_LSB] <= next_chan;
      word[`TIR_W_OPEN_MSB:`TIR_W_OPEN_LSB] <= conv_open;
    end
  end

  // Status word: fresh flags and the channel the front end is showing,
  // taken from the select pin so software sees what the pin shows
  assign stat_word = {24'h000000, fresh, 2'h0, adc_sel};

  // Read multiplexer; unmapped offsets read zero
  always @* begin
    case (haddr)
      `TIR_ADDR_INPUT: begin
        next_rdata = word;
      end
      `TIR_ADDR_CTRL: begin
        next_rdata = ctrl;
      end
      `TIR_ADDR_STAT: begin
        next_rdata = stat_word;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Response is fixed: zero wait states and always OKAY, so a master
  // can never stall on this slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data loaded at the address phase, held until the next read
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // Write capture: the data only arrives one cycle after the address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      if (take) begin
        wr_addr <= haddr;
      end
    end
  end

  // Control register lands in the data phase; only six bits are kept
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `TIR_CTRL_RESET;
    end else if (wr_pend && wr_addr == `TIR_ADDR_CTRL) begin
      ctrl <= {26'h0, hwdata[5:0]};
    end
  end

  // Channel select re-registered so the pin leaves a flop of this module
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_sel <= 2'h0;
    end else begin
      adc_sel <= conv_sel;
    end
  end

endmodule // tir_input_word

// File: test/tir_front_model.sv
// Front end model: one fixed reading per selected channel
`timescale 1ns/1ps
module tir_front_model (
  input wire [1:0] adc_sel,
  output wire [15:0] adc_value,
  output wire adc_negative
);
  // Channel code rides in the value so a mispaired word shows
  assign adc_value = {2'b10, adc_sel, 12'h5a3};
  assign adc_negative = adc_sel[0];
endmodule // tir_front_model

// File: test/tir_input_word_props.sv
// Checker for the temperature input word slave
`timescale 1ns/1ps
module tir_input_word_props #(
  parameter [31:0] CONV_CYCLES = 32'd6400000
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [1:0] adc_sel
);
  // Read taken at this edge
  wire rd = hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout == 1'b1)
    else $error("not ready");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bad response");
  word_rsv_a: assert property (rd && haddr == 8'h00 |=>
    hrdata[31:28] == 4'h0 && hrdata[23:18] == 6'h00)
    else $error("spare bits set");
  rdata_hold_a: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  sel_hold_a:
    assert property ($changed(adc_sel) |=> $stable(adc_sel) [*8])
    else $error("channel switched early");
  dead_zero_a: assert property (rd && haddr == 8'h0c |=>
    hrdata == 32'h0) else $error("unmapped not zero");
  ctrl_rsv_a: assert property (rd && haddr == 8'h04 |=>
    hrdata[31:6] == 26'h0) else $error("control spare set");
  stat_sel_a:
    assert property (rd && haddr == 8'h08 |=> hrdata[1:0] == $past(adc_sel))
    else $error("status channel wrong");
endmodule // tir_input_word_props

bind tir_input_word tir_input_word_props #(.CONV_CYCLES(CONV_CYCLES))
  tir_input_word_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .adc_sel(adc_sel));

// File: test/tb_tir_input_word.sv
// Self-checking bench for the temperature input word slave
`timescale 1ns/1ps
module tb_tir_input_word;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg [7:0] haddr = 8'h00;
  reg [1:0] htrans = 2'b00;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] sensor_open = 4'h5;
  wire [31:0] hrdata;
  wire hreadyout, hresp, adc_negative;
  wire [15:0] adc_value;
  wire [1:0] adc_sel;
  reg [31:0] w;
  reg [1:0] c;
  integer errors = 0, check_count = 0, i, f;
  // 40 MHz bus clock
  always #12.5 hclk = ~hclk;
  // Short conversion period keeps the run brief
  tir_input_word #(.CONV_CYCLES(32'd20)) tir_input_word_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .adc_value(adc_value), .adc_negative(adc_negative),
    .sensor_open(sensor_open), .adc_sel(adc_sel));
  tir_front_model tir_front_model_inst (.adc_sel(adc_sel),
    .adc_value(adc_value), .adc_negative(adc_negative));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Bounded wait for ready so a hung slave still reaches the verdict
  task wait_rdy;
    integer n;
    begin
      n = 0;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
      if (hreadyout !== 1'b1) begin
        errors = errors + 1;
        test_done;
      end
    end
  endtask
  // Single word transfer: address phase, then data phase
  task bus(input wr, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Expected word for a channel code, format and open pattern
  function [31:0] exp_w(input [1:0] ch, input [1:0] fm, input [3:0] op);
    reg [15:0] m;
    begin
      m = {2'b00, ch, 12'h5a3};
      if (fm == 2'd0)
        m = {2'b10, ch, 12'h5a3};
      else if (fm == 2'd1)
        m[15] = ch[0];
      else if (ch[0])
        m = -m;
      exp_w = {4'h0, op, 6'h00, ch, m};
    end
  endfunction
  // Reset values, then a unipolar pass over all channels with a wrap
  task t_scan;
    begin
      bus(1'b0, 8'h04, 32'h0, w);
      chk(w, 32'h0000000f);
      bus(1'b1, 8'h0c, 32'hffffffff, w);
      bus(1'b0, 8'h0c, 32'h0, w);
      chk(w, 32'h0);
      bus(1'b0, 8'h08, 32'h0, w);
      chk(w, 32'h0);
      repeat (120) @(posedge hclk);
      bus(1'b0, 8'h08, 32'h0, w);
      chk(w & 32'h000000f0, 32'h000000f0);
      bus(1'b1, 8'h00, 32'hffffffff, w);
      bus(1'b0, 8'h00, 32'h0, w);
      chk(w, 32'h0);
      for (i = 0; i < 5; i = i + 1) begin
        bus(1'b0, 8'h00, 32'h0, w);
        chk(w, exp_w(2'(i + 1), 2'd0, 4'h5));
      end
      $display("scan test done");
    end
  endtask
  // Two channels on: others skipped, open bits follow the pins
  task t_skip;
    begin
      bus(1'b1, 8'h04, 32'h0000000a, w);
      sensor_open <= 4'ha;
      repeat (10) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0, w);
      chk(w, exp_w(2'd2, 2'd0, 4'h5));
      for (i = 0; i < 3; i = i + 1) begin
        bus(1'b0, 8'h00, 32'h0, w);
        chk(w, exp_w(i[0] ? 2'd1 : 2'd3, 2'd0, 4'ha));
      end
      $display("skip test done");
    end
  endtask
  // Bipolar formats; odd channels read negative
  task t_format;
    begin
      for (f = 1; f < 3; f = f + 1) begin
        bus(1'b1, 8'h04, (f == 1) ? 32'h1f : 32'h3f, w);
        repeat (120) @(posedge hclk);
        bus(1'b0, 8'h00, 32'h0, w);
        for (i = 0; i < 4; i = i + 1) begin
          c = 2'(f + 1 + i);
          bus(1'b0, 8'h00, 32'h0, w);
          chk(w, exp_w(c, 2'(f), 4'ha));
          if (c[0] && f == 1)
            chk(w & 32'h00007fff, {18'h0, c, 12'h5a3});
          if (c[0] && f == 2)
            chk({16'h0, ~w[15:0] + 16'h1}, {18'h0, c, 12'h5a3});
        end
      end
      $display("format test done");
    end
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_scan;
    t_skip;
    t_format;
    test_done;
  end
endmodule // tb_tir_input_word
